/* File: shared/etx_pkg.sv */
package etx_pkg;

    // ------------------------------------------------------------
    // Channel count and timing
    // ------------------------------------------------------------
    localparam int                CHANNELS      = 22;
    localparam int                CH_W          = 5;
    localparam logic [CH_W-1:0]   CH_LIMIT      = CH_W'(CHANNELS);
    localparam int                CLK_PERIOD_NS = 20;
    localparam int                WINDOW_NS     = 1000;
    localparam int                WINDOW_CYCLES = WINDOW_NS / CLK_PERIOD_NS;
    localparam int                MISS_TIME_NS  = 10000;
    localparam int                MISS_WINDOWS  = MISS_TIME_NS / WINDOW_NS;
    localparam int                DUTY_MIN_PCT  = 30;
    localparam int                WIN_W         = 6;
    localparam int                MISS_W        = 4;
    localparam logic [WIN_W-1:0]  WIN_LAST      = WIN_W'(WINDOW_CYCLES - 1);
    localparam logic [WIN_W-1:0]  DUTY_LIMIT    = WIN_W'((WINDOW_CYCLES * DUTY_MIN_PCT + 99) / 100);
    localparam logic [MISS_W-1:0] MISS_LAST     = MISS_W'(MISS_WINDOWS - 1);

    // ------------------------------------------------------------
    // Modes, selections and carriers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ETX_SINGLE_NRZ = 2'h0,
        ETX_DUAL_NRZ   = 2'h1,
        ETX_DUAL_RZ    = 2'h3
    } etx_mode_e;

    typedef enum logic [2:0] {
        ETX_IND_PATTERN  = 3'h0,
        ETX_IND_ALARM    = 3'h1,
        ETX_IND_OUTCLK   = 3'h2,
        ETX_IND_TXLOSS   = 3'h3,
        ETX_IND_EXZ      = 3'h4,
        ETX_IND_BPV      = 3'h5,
        ETX_IND_EXZ_BPV  = 3'h6,
        ETX_IND_LOSS     = 3'h7
    } etx_ind_e;

    typedef enum logic [1:0] {
        ETX_MON_RUN     = 2'h0,
        ETX_MON_MISSING = 2'h1,
        ETX_MON_RECOVER = 2'h3
    } etx_mon_e;

    typedef struct packed {
        etx_mode_e mode;
        logic      invert;
        logic      edgeFalling;
        etx_ind_e  indSel;
    } etx_cfg_s;

    typedef struct packed {
        logic loss;
        logic bipolarViolation;
        logic excessZero;
        logic transmitLoss;
        logic outputClock;
        logic sendAlarm;
        logic patternTest;
    } etx_status_s;

    localparam etx_cfg_s CFG_RESET = '{mode: ETX_SINGLE_NRZ, invert: 1'b0, edgeFalling: 1'b0,
                                       indSel: ETX_IND_PATTERN};

    // ------------------------------------------------------------
    // Shared decoding
    // ------------------------------------------------------------
    function automatic logic [7:0] etx_status_vector(input etx_status_s s);
        return {s.loss, s.excessZero | s.bipolarViolation, s.bipolarViolation, s.excessZero,
                s.transmitLoss, s.outputClock, s.sendAlarm, s.patternTest};
    endfunction : etx_status_vector

    function automatic logic [3:0] etx_multiple(input logic [3:0] code);
        if (code[3]) begin
            return {1'b0, code[2:0]} + 4'h1;
        end
        return 4'h0;
    endfunction : etx_multiple

endpackage : etx_pkg

/* File: hdl/etx_link_channel.sv */
`timescale 1ns/100ps
module etx_link_channel (
    // Link clock and reset
    input  wire logic              txSystemClock,
    input  wire logic              rst_b,
    // Configuration from the system domain
    input  wire logic              edgeFalling,
    input  wire etx_pkg::etx_cfg_s cfg,
    input  wire logic [7:0]        statusVec,
    // Data pins
    input  wire logic              txPositiveRailData,
    input  wire logic              txNegativeRailData,
    // Sampled results
    output logic                   linkTip,
    output logic                   linkRing,
    output logic                   linkIndication
);
    import etx_pkg::*;

    // ------------------------------------------------------------
    // Active edge and local reset
    // ------------------------------------------------------------
    // Edge select is static: changing it glitches this clock
    logic       chClk;
    logic [1:0] rstPipe;
    logic       linkRst_b;
    assign chClk     = txSystemClock ^ edgeFalling;
    assign linkRst_b = rstPipe[1];

    always_ff @(posedge chClk or negedge rst_b) begin
        if (!rst_b) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end

    // ------------------------------------------------------------
    // Crossings into the link domain
    // ------------------------------------------------------------
    // Bits cross one by one; selections must be quiet while changed
    logic [13:0] cfgMeta;
    logic [13:0] cfgSync;
    logic [1:0]  posPipe;
    logic [1:0]  negPipe;
    logic        singleRail;
    logic        selInd;
    logic        posLvl;
    logic        negLvl;
    assign singleRail = cfgSync[13:12] == ETX_SINGLE_NRZ;
    assign selInd     = cfgSync[cfgSync[10:8]];
    assign posLvl     = posPipe[1] ^ cfgSync[11];
    assign negLvl     = negPipe[1] ^ cfgSync[11];

    always_ff @(posedge chClk or negedge linkRst_b) begin
        if (!linkRst_b) begin
            cfgMeta        <= 14'h0;
            cfgSync        <= 14'h0;
            posPipe        <= 2'h0;
            negPipe        <= 2'h0;
            linkTip        <= 1'b0;
            linkRing       <= 1'b0;
            linkIndication <= 1'b0;
        end else begin
            cfgMeta        <= {cfg.mode, cfg.invert, cfg.indSel, statusVec};
            cfgSync        <= cfgMeta;
            posPipe        <= {posPipe[0], txPositiveRailData};
            negPipe        <= {negPipe[0], txNegativeRailData};
            // In dual NRZ equal rails are a space, so neither pulse flop is set; single NRZ tip follows the positive rail
            linkTip        <= singleRail ? posLvl : posLvl & ~negLvl;
            linkRing       <= !singleRail && negLvl && !posLvl;
            linkIndication <= selInd;
        end
    end

endmodule : etx_link_channel

/* File: hdl/etx_tx_system_interface.sv */
`timescale 1ns/100ps
// Functional notes
// - Twenty-two independent channels, numbered zero to twenty-one
// - Invert bit sets data rail active level
// - Single NRZ or dual RZ: pin indicates
// - Three-bit selector picks indicated status condition
// - Indication updates on active transmit clock edge, on clk in dual RZ
// - Indication output always active high
// - NRZ data sampled on active clock edge
// - Edge bit picks rising or falling edge
// - Dual RZ: clock pin is negative rail
// - Reset after master clock lost then recovers
// - Four straps give master clock multiple
// - Dual rails map to pulse, pulse, space
// - Single NRZ takes unipolar data on one pin
module etx_tx_system_interface (
    // Clock and reset
    input  wire logic                                      clk,
    input  wire logic                                      rst_b,
    // Master clock and frequency straps
    input  wire logic                                      masterClock,
    input  wire logic [3:0]                                masterClockFreqSelect,
    output logic [3:0]                                     masterClockMultiple,
    output logic                                           masterClockSelectValid,
    output logic                                           masterClockLost,
    output logic                                           autoResetPulse,
    // Channel configuration
    input  wire logic                                      cfgWrite,
    input  wire logic [etx_pkg::CH_W-1:0]                  cfgChannel,
    input  wire etx_pkg::etx_cfg_s                         cfgData,
    output etx_pkg::etx_cfg_s                              cfgReadData,
    // Status conditions
    input  wire etx_pkg::etx_status_s [etx_pkg::CHANNELS-1:0] channelStatus,
    // System pins
    input  wire logic [etx_pkg::CHANNELS-1:0]              txSystemClock,
    input  wire logic [etx_pkg::CHANNELS-1:0]              txPositiveRailData,
    input  wire logic [etx_pkg::CHANNELS-1:0]              txNegativeRailData,
    output logic [etx_pkg::CHANNELS-1:0]                   txIndicationOut,
    output logic [etx_pkg::CHANNELS-1:0]                   txIndicationOutEn,
    // Line side symbols
    output logic [etx_pkg::CHANNELS-1:0]                   lineTipOut,
    output logic [etx_pkg::CHANNELS-1:0]                   lineRingOut
);
    import etx_pkg::*;

    // ------------------------------------------------------------
    // Frequency straps
    // ------------------------------------------------------------
    logic [3:0] strapMeta;
    logic [3:0] strapSync;
    logic [1:0] strapArm;
    logic       strapDone;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            strapMeta              <= 4'h0;
            strapSync              <= 4'h0;
            strapArm               <= 2'h0;
            strapDone              <= 1'b0;
            masterClockMultiple    <= 4'h0;
            masterClockSelectValid <= 1'b0;
        end else begin
            strapMeta <= masterClockFreqSelect;
            strapSync <= strapMeta;
            strapArm  <= {strapArm[0], 1'b1};
            // Straps are static, so one capture after release is enough
            if (strapArm[1] && !strapDone) begin
                strapDone              <= 1'b1;
                masterClockMultiple    <= etx_multiple(strapSync);
                masterClockSelectValid <= strapSync[3];
            end
        end
    end

    // ------------------------------------------------------------
    // Master clock monitor
    // ------------------------------------------------------------
    logic              mclkMeta;
    logic              mclkSync;
    etx_mon_e          monState;
    etx_mon_e          next_monState;
    logic [WIN_W-1:0]  winCount;
    logic [WIN_W-1:0]  highCount;
    logic [MISS_W-1:0] missWindows;
    wire               windowEnd  = winCount == WIN_LAST;
    wire [WIN_W-1:0]   windowHigh = highCount + WIN_W'(mclkSync);
    wire               lowDuty    = windowHigh < DUTY_LIMIT;
    wire               lowRunDone = lowDuty && missWindows == MISS_LAST;
    wire               recovered  = monState == ETX_MON_MISSING && windowEnd && !lowDuty;

    always_comb begin
        next_monState = monState;
        case (monState)
            ETX_MON_RUN: begin
                if (windowEnd && lowRunDone) begin
                    next_monState = ETX_MON_MISSING;
                end
            end
            ETX_MON_MISSING: begin
                if (recovered) begin
                    next_monState = ETX_MON_RECOVER;
                end
            end
            ETX_MON_RECOVER: begin
                next_monState = ETX_MON_RUN;
            end
            default: begin
                next_monState = ETX_MON_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mclkMeta        <= 1'b0;
            mclkSync        <= 1'b0;
            monState        <= ETX_MON_RUN;
            winCount        <= '0;
            highCount       <= '0;
            missWindows     <= '0;
            masterClockLost <= 1'b0;
            autoResetPulse  <= 1'b0;
        end else begin
            mclkMeta        <= masterClock;
            mclkSync        <= mclkMeta;
            monState        <= next_monState;
            winCount        <= windowEnd ? '0 : winCount + WIN_W'(1);
            highCount       <= windowEnd ? '0 : windowHigh;
            masterClockLost <= next_monState == ETX_MON_MISSING;
            autoResetPulse  <= recovered;
            if (windowEnd) begin
                missWindows <= (lowDuty && !lowRunDone) ? missWindows + MISS_W'(1) : '0;
            end
        end
    end

    // ------------------------------------------------------------
    // Channel configuration store
    // ------------------------------------------------------------
    etx_cfg_s cfgMem [CHANNELS];
    // Reserved mode code and unknown channels are refused
    wire      cfgAccept = cfgWrite && cfgChannel < CH_LIMIT && cfgData.mode != 2'h2;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < CHANNELS; i++) begin
                cfgMem[i] <= CFG_RESET;
            end
            cfgReadData <= CFG_RESET;
        end else begin
            // Recovery reset beats a write in the same cycle
            if (autoResetPulse) begin
                for (int i = 0; i < CHANNELS; i++) begin
                    cfgMem[i] <= CFG_RESET;
                end
            end else if (cfgAccept) begin
                cfgMem[cfgChannel] <= cfgData;
            end
            cfgReadData <= (cfgChannel < CH_LIMIT) ? cfgMem[cfgChannel] : CFG_RESET;
        end
    end

    // ------------------------------------------------------------
    // Per-channel pin multiplexing
    // ------------------------------------------------------------
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : gChan
        logic       rzTip;
        logic       rzRing;
        logic       rzInd;
        logic       indEn;
        logic [1:0] rzPosPipe;
        logic [1:0] rzNegPipe;
        logic       linkTip;
        logic       linkRing;
        logic       linkInd;
        wire        isRz      = cfgMem[ch].mode == ETX_DUAL_RZ;
        wire        drivesInd = cfgMem[ch].mode != ETX_DUAL_NRZ;
        wire [7:0]  statusVec = etx_status_vector(channelStatus[ch]);
        wire        selInd    = statusVec[cfgMem[ch].indSel];
        wire        rzPosLvl  = rzPosPipe[1] ^ cfgMem[ch].invert;
        wire        rzNegLvl  = rzNegPipe[1] ^ cfgMem[ch].invert;

        // No clock in RZ mode, so system clock samples both rails
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                rzPosPipe <= 2'h0;
                rzNegPipe <= 2'h0;
                rzTip     <= 1'b0;
                rzRing    <= 1'b0;
                rzInd     <= 1'b0;
                indEn     <= 1'b0;
            end else begin
                rzPosPipe <= {rzPosPipe[0], txPositiveRailData[ch]};
                rzNegPipe <= {rzNegPipe[0], txSystemClock[ch]};
                rzTip     <= rzPosLvl & ~rzNegLvl;
                rzRing    <= rzNegLvl & ~rzPosLvl;
                rzInd     <= selInd;
                indEn     <= drivesInd;
            end
        end

        etx_link_channel uLink (
            .txSystemClock      (txSystemClock[ch]),
            .rst_b              (rst_b),
            .edgeFalling        (cfgMem[ch].edgeFalling),
            .cfg                (cfgMem[ch]),
            .statusVec          (statusVec),
            .txPositiveRailData (txPositiveRailData[ch]),
            .txNegativeRailData (txNegativeRailData[ch]),
            .linkTip            (linkTip),
            .linkRing           (linkRing),
            .linkIndication     (linkInd)
        );

        // Mode picks which domain's flop reaches the pin
        assign txIndicationOut[ch]   = isRz ? rzInd : linkInd;
        assign txIndicationOutEn[ch] = indEn;
        assign lineTipOut[ch]        = isRz ? rzTip : linkTip;
        assign lineRingOut[ch]       = isRz ? rzRing : linkRing;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cbMain @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence seqRecoverSeen;
        recovered;
    endsequence

    sequence seqOnePulse;
        autoResetPulse ##1 !autoResetPulse;
    endsequence

    sequence seqWriteDualNrz0;
        cfgAccept && cfgChannel == 5'h0 && cfgData.mode == ETX_DUAL_NRZ && !autoResetPulse;
    endsequence

    wire selIndCh0  = gChan[0].selInd;
    wire rzPosCh0   = (gChan[0].rzPosPipe[1] ^ cfgMem[0].invert) & ~(gChan[0].rzNegPipe[1] ^ cfgMem[0].invert);

    recover_pulse_a: assert property (seqRecoverSeen |=> seqOnePulse)
        else $error("Recovery did not give one reset pulse");
    miss_entry_a: assert property (monState == ETX_MON_RUN && windowEnd && lowRunDone
                                   |=> monState == ETX_MON_MISSING ##1 masterClockLost)
        else $error("Ten low duty windows did not flag a missing clock");
    pulse_cause_a: assert property ($rose(autoResetPulse) |-> $past(monState) == ETX_MON_MISSING)
        else $error("Reset pulse without a missing clock");
    reset_defaults_a: assert property (autoResetPulse |=> cfgMem[5] == CFG_RESET && cfgMem[21] == CFG_RESET)
        else $error("Recovery reset left channel settings");
    cfg_store_a: assert property (cfgAccept && !autoResetPulse
                                  |=> cfgMem[$past(cfgChannel)] == $past(cfgData))
        else $error("Accepted setting not stored");
    pin_release_a: assert property (seqWriteDualNrz0 |=> ##1 !txIndicationOutEn[0])
        else $error("Indication pin driven in dual NRZ");
    strap_decode_a: assert property ($rose(strapDone)
                                     |-> masterClockMultiple == etx_multiple($past(strapSync)))
        else $error("Strap multiple decoded wrongly");
    rz_indicate_a: assert property (gChan[0].isRz && $stable(cfgMem[0])
                                    |-> txIndicationOut[0] == $past(selIndCh0))
        else $error("RZ indication not the selected status");
    rz_invert_a: assert property (gChan[0].isRz && $stable(cfgMem[0])
                                  |-> lineTipOut[0] == $past(rzPosCh0))
        else $error("RZ positive rail polarity wrong");

endmodule : etx_tx_system_interface

/* File: testbench/etx_framer_model.sv */
`timescale 1ns/100ps
module etx_framer_model (
    // Pins toward the device
    output logic txClk,
    output logic posData,
    output logic negData
);
    initial begin
        txClk   = 1'b0;
        posData = 1'b0;
        negData = 1'b0;
    end

    // Clock runs only inside a frame; lines flip afterwards so stale data never passes
    task automatic send(input logic pos, input logic neg, input int edges);
        posData = pos;
        negData = neg;
        repeat (edges) begin
            #3 txClk = 1'b1;
            #3 txClk = 1'b0;
        end
        #2 posData = ~pos;
        negData = ~neg;
    endtask : send

    // Dual RZ: symbols already encoded, clock pin carries the negative rail
    task automatic rz_set(input logic pos, input logic neg);
        posData = pos;
        txClk   = neg;
    endtask : rz_set
endmodule : etx_framer_model

/* File: testbench/etx_tx_system_interface_test.sv */
`timescale 1ns/100ps
module etx_tx_system_interface_test;
    import etx_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic                       clk, rst_b, masterClock, mclkRun, cfgWrite, fmClk, fmPos, fmNeg;
    logic [3:0]                 masterClockFreqSelect, masterClockMultiple;
    logic                       masterClockSelectValid, masterClockLost, autoResetPulse;
    logic [CH_W-1:0]            cfgChannel;
    etx_cfg_s                   cfgData, cfgReadData;
    etx_status_s [CHANNELS-1:0] channelStatus;
    logic [CHANNELS-1:0]        txIndicationOut, txIndicationOutEn, lineTipOut, lineRingOut, negPin;
    int                         mismatches, n_checks;

    // Shared pin level: device wins while it drives
    assign negPin = {21'h0, txIndicationOutEn[0] ? txIndicationOut[0] : fmNeg};

    etx_framer_model i_etx_framer_model (.txClk(fmClk), .posData(fmPos), .negData(fmNeg));
    etx_tx_system_interface i_etx_tx_system_interface (
        .clk(clk), .rst_b(rst_b), .masterClock(masterClock), .masterClockFreqSelect(masterClockFreqSelect),
        .masterClockMultiple(masterClockMultiple), .masterClockSelectValid(masterClockSelectValid),
        .masterClockLost(masterClockLost), .autoResetPulse(autoResetPulse), .cfgWrite(cfgWrite),
        .cfgChannel(cfgChannel), .cfgData(cfgData), .cfgReadData(cfgReadData), .channelStatus(channelStatus),
        .txSystemClock({21'h0, fmClk}), .txPositiveRailData({21'h0, fmPos}), .txNegativeRailData(negPin),
        .txIndicationOut(txIndicationOut), .txIndicationOutEn(txIndicationOutEn),
        .lineTipOut(lineTipOut), .lineRingOut(lineRingOut));

    // ------------------------------------------------------------
    // Clocks
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Master clock period of 100 ns so that 20 ns sampling cannot alias
    always begin
        masterClock = mclkRun === 1'b1;
        #50 masterClock = 1'b0;
        #50;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    function automatic logic [1:0] sym(input logic p, input logic n, input logic inv);
        return {(p ^ inv) & ~(n ^ inv), (n ^ inv) & ~(p ^ inv)};
    endfunction : sym

    function automatic logic ind(input logic [2:0] sel, input etx_status_s s);
        case (sel)
            3'h0: return s.patternTest;
            3'h1: return s.sendAlarm;
            3'h2: return s.outputClock;
            3'h3: return s.transmitLoss;
            3'h4: return s.excessZero;
            3'h5: return s.bipolarViolation;
            3'h6: return s.excessZero | s.bipolarViolation;
            default: return s.loss;
        endcase
    endfunction : ind

    task automatic do_reset(input logic [3:0] code);
        rst_b = 1'b0;
        masterClockFreqSelect = code;
        fork
            repeat (8) @(negedge clk);
            i_etx_framer_model.send(1'b0, 1'b0, 4);
        join
        rst_b = 1'b1;
        i_etx_framer_model.send(1'b0, 1'b0, 6);
        repeat (4) @(negedge clk);
    endtask : do_reset

    task automatic write_cfg(input logic [4:0] ch, input logic [1:0] m, input logic inv, fall, input logic [2:0] sel);
        cfgChannel = ch;
        cfgData    = '{mode: etx_mode_e'(m), invert: inv, edgeFalling: fall, indSel: etx_ind_e'(sel)};
        cfgWrite   = 1'b1;
        @(negedge clk);
        cfgWrite = 1'b0;
        repeat (2) @(negedge clk);
    endtask : write_cfg

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_straps();
        logic [3:0] codes [6];
        codes = '{4'h9, 4'hA, 4'hB, 4'hF, 4'h0, 4'h8};
        foreach (codes[i]) begin
            do_reset(codes[i]);
            check("multiple", codes[i][3] ? 8'(codes[i][2:0]) + 8'h1 : 8'h0, 8'(masterClockMultiple));
            check("select valid", 8'(codes[i][3]), 8'(masterClockSelectValid));
        end
        check("cfg default", 8'(CFG_RESET), 8'(cfgReadData));
    endtask : test_straps

    task automatic test_config();
        write_cfg(5'h15, 2'h1, 1'b1, 1'b0, 3'h5);
        check("cfg ch21", 8'h35, 8'(cfgReadData));
        check("pin en ch21", 8'h0, 8'(txIndicationOutEn[21]));
        write_cfg(5'h0, 2'h2, 1'b1, 1'b1, 3'h7);
        check("mode 2 dropped", 8'(CFG_RESET), 8'(cfgReadData));
        write_cfg(5'h16, 2'h1, 1'b1, 1'b1, 3'h7);
        check("ch22 dropped", 8'(CFG_RESET), 8'(cfgReadData));
    endtask : test_config

    task automatic test_rz();
        for (int i = 0; i < 8; i++) begin
            write_cfg(5'h0, 2'h3, i[2], 1'b0, 3'h0);
            check("rz pin en", 8'h1, 8'(txIndicationOutEn[0]));
            i_etx_framer_model.rz_set(i[0], i[1]);
            repeat (4) @(negedge clk);
            check("rz symbol", 8'(sym(i[0], i[1], i[2])), 8'({lineTipOut[0], lineRingOut[0]}));
        end
        // Two patterns so every selector sees both levels
        for (int s = 0; s < 16; s++) begin
            write_cfg(5'h0, 2'h3, 1'b0, 1'b0, s[2:0]);
            channelStatus[0] = etx_status_s'(s[3] ? 7'h4A : 7'h35);
            repeat (3) @(negedge clk);
            check("indication", 8'(ind(s[2:0], channelStatus[0])), 8'(txIndicationOut[0]));
        end
    endtask : test_rz

    task automatic test_nrz();
        for (int i = 0; i < 16; i++) begin
            write_cfg(5'h0, i[3] ? 2'h1 : 2'h0, i[2], i[1], 3'h7);
            check("nrz pin en", 8'(!i[3]), 8'(txIndicationOutEn[0]));
            channelStatus[0] = etx_status_s'(i[0] ? 7'h40 : 7'h00);
            i_etx_framer_model.send(i[0], ~i[0], 8);
            repeat (2) @(negedge clk);
            check("nrz symbol", i[3] ? 8'(sym(i[0], ~i[0], i[2])) : 8'({i[0] ^ i[2], 1'b0}),
                  8'({lineTipOut[0], lineRingOut[0]}));
            if (!i[3]) begin
                check("nrz indication", 8'(i[0]), 8'(txIndicationOut[0]));
            end
        end
    endtask : test_nrz

    task automatic test_mclk();
        int n;
        write_cfg(5'h0, 2'h3, 1'b1, 1'b1, 3'h2);
        check("no loss", 8'h0, 8'(masterClockLost));
        mclkRun = 1'b0;
        n = 0;
        while (masterClockLost !== 1'b1 && n < 800) begin
            @(negedge clk);
            n++;
        end
        check("loss after 10 us", 8'h1, 8'(n >= 450 && n < 800));
        check("cfg kept while lost", 8'h7A, 8'(cfgReadData));
        mclkRun = 1'b1;
        n = 0;
        while (autoResetPulse !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        check("auto reset", 8'h1, 8'(autoResetPulse));
        repeat (2) @(negedge clk);
        check("defaults restored", 8'(CFG_RESET), 8'(cfgReadData));
        check("lost cleared", 8'h0, 8'(masterClockLost));
        check("straps kept", 8'h1, 8'(masterClockMultiple));
    endtask : test_mclk

    task automatic finish_test();
        $display("Checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------
    // Sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        rst_b                 = 1'b0;
        mclkRun               = 1'b1;
        cfgWrite              = 1'b0;
        cfgChannel            = 5'h0;
        cfgData               = CFG_RESET;
        masterClockFreqSelect = 4'h8;
        channelStatus         = '0;
        mismatches            = 0;
        n_checks              = 0;
        @(negedge clk);
        test_straps();
        test_config();
        test_rz();
        test_nrz();
        test_mclk();
        finish_test();
    end

    // Whole run is about 20 us; this only trips on a hang
    initial begin
        #300000;
        mismatches++;
        finish_test();
    end
endmodule : etx_tx_system_interface_test
